// ===== hdl/cisa_core.v
// Purpose: decode and execute immediate, register-pair, high-register and
//  pc-relative load formats of the compact instruction set
// Assumes: instr_valid offered only while instr_ready is high; memory read
//  data arrives with mem_rvalid some cycles after mem_req
// Notes: other formats are ignored and retire in one cycle
`timescale 1ns/1ps
`include "cisa_defs.vh"
module cisa_core
#(
	parameter WIDTH = 32,
	parameter NREGS = 16
)
(
	// clock and reset
	input wire clock,
	input wire rst,
	// instruction fetch side
	input wire instr_valid,
	input wire [15:0] instr,
	input wire [WIDTH-1:0] instr_addr,
	output wire instr_ready,
	// memory read path for the pc-relative load
	output reg mem_req,
	output reg [WIDTH-1:0] mem_addr,
	input wire mem_rvalid,
	input wire [WIDTH-1:0] mem_rdata,
	// architectural state seen by the rest of the core
	output reg [3:0] status_flags_reg,
	output reg compact_state,
	output reg branch_taken,
	output reg [WIDTH-1:0] branch_target,
	output reg [WIDTH-1:0] reg_view,
	input wire [3:0] reg_view_sel
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_LOAD = 2'h2;
	reg [WIDTH-1:0] regs [0:NREGS-1];
	reg [1:0] state;
	reg [2:0] wait_cnt;
	reg [2:0] load_dest;
	reg [2:0] next_cycles;
	reg next_wr;
	reg [3:0] next_wr_idx;
	reg [WIDTH-1:0] next_wr_val;
	reg next_flags_wr;
	reg [3:0] next_flags;
	reg next_branch;
	reg next_load;
	reg [WIDTH-1:0] dst_op;
	reg [WIDTH-1:0] src_op;
	reg [3:0] dst_idx;
	reg [3:0] src_idx;
	reg [WIDTH:0] isum;
	wire [WIDTH-1:0] alu_res;
	wire alu_c;
	wire alu_v;
	wire alu_arith;
	wire [WIDTH-1:0] pc_read;
	wire is_f3;
	wire is_f4;
	wire is_f5;
	wire is_f6;
	wire [7:0] imm8_field;
	wire dest_bank_flag;
	wire src_bank_flag;
	integer k;

	// register read with pc substitution
	function [WIDTH-1:0] read_reg;
		input [3:0] idx;
		input [WIDTH-1:0] pcv;
		input [WIDTH-1:0] val;
		begin
			read_reg = (idx == `CISA_PC_INDEX) ? pcv : val;
		end
	endfunction

	// build n z c v from a result
	function [3:0] mk_flags;
		input [WIDTH-1:0] res;
		input c;
		input v;
		begin
			mk_flags = {res[WIDTH-1], ~|res, c, v};
		end
	endfunction

	assign pc_read = (instr_addr + `CISA_PC_AHEAD) & ~{{(WIDTH-1){1'b0}}, 1'b1};
	assign is_f3 = instr[15:13] == `CISA_F3_TAG;
	assign is_f4 = instr[15:10] == `CISA_F4_TAG;
	assign is_f5 = instr[15:10] == `CISA_F5_TAG;
	assign is_f6 = instr[15:11] == `CISA_F6_TAG;
	assign imm8_field = instr[7:0];
	assign dest_bank_flag = instr[7];
	assign src_bank_flag = instr[6];
	// stalled while a multi-cycle op or load is in flight
	assign instr_ready = state == ST_IDLE;

	cisa_alu #(.WIDTH(WIDTH)) u_alu
	(
		.op(instr[9:6]),
		.dst_val(dst_op),
		.src_val(src_op),
		.carry_in(status_flags_reg[`CISA_FLAG_C]),
		.result(alu_res),
		.carry_out(alu_c),
		.ovf_out(alu_v),
		.arith(alu_arith)
	);

	// operand selection per format
	always @*
	begin
		dst_idx = {1'b0, instr[2:0]};
		src_idx = {1'b0, instr[5:3]};
		if (is_f3)
			dst_idx = {1'b0, instr[10:8]};
		if (is_f5)
		begin
			dst_idx = {dest_bank_flag, instr[2:0]};
			src_idx = {src_bank_flag, instr[5:3]};
		end
		dst_op = read_reg(dst_idx, pc_read, regs[dst_idx]);
		src_op = read_reg(src_idx, pc_read, regs[src_idx]);
	end

	// decode: what gets written, and how many cycles the op takes
	always @*
	begin
		next_wr = 1'b0;
		next_wr_idx = dst_idx;
		next_wr_val = alu_res;
		next_flags_wr = 1'b0;
		next_flags = status_flags_reg;
		next_branch = 1'b0;
		next_load = 1'b0;
		next_cycles = `CISA_CYC_ALU;
		isum = {(WIDTH+1){1'b0}};
		if (is_f3)
		begin
			next_flags_wr = 1'b1;
			case (instr[12:11])
			`CISA_IMM_MOV:
			begin
				next_wr = 1'b1;
				next_wr_val = {{(WIDTH-8){1'b0}}, imm8_field};
				next_flags = {1'b0, ~|imm8_field, status_flags_reg[1:0]};
			end
			`CISA_IMM_ADD:
			begin
				isum = {1'b0, dst_op} + {{(WIDTH-7){1'b0}}, imm8_field};
				next_wr = 1'b1;
				next_wr_val = isum[WIDTH-1:0];
				next_flags = mk_flags(isum[WIDTH-1:0], isum[WIDTH],
					~dst_op[WIDTH-1] & isum[WIDTH-1]);
			end
			default: // subtract, and compare which does not write back
			begin
				isum = {1'b0, dst_op} + {1'b0, ~{{(WIDTH-8){1'b0}}, imm8_field}} +
					{{WIDTH{1'b0}}, 1'b1};
				next_wr = instr[12:11] == `CISA_IMM_SUB;
				next_wr_val = isum[WIDTH-1:0];
				next_flags = mk_flags(isum[WIDTH-1:0], isum[WIDTH],
					dst_op[WIDTH-1] & ~isum[WIDTH-1]);
			end
			endcase
		end
		else if (is_f4)
		begin
			next_flags_wr = 1'b1;
			// test, compare and compare-negative keep the destination
			next_wr = !(instr[9:6] == `CISA_ALU_TEST || instr[9:6] == `CISA_ALU_CMP ||
				instr[9:6] == `CISA_ALU_CMPN);
			next_flags = mk_flags(alu_res, alu_c,
				alu_arith ? alu_v : status_flags_reg[`CISA_FLAG_V]);
			// register-specified shifts and multiply cost extra cycles
			if (instr[9:6] == `CISA_ALU_MULT)
				next_cycles = `CISA_CYC_MULT;
			else if (instr[9:6] == `CISA_ALU_SHL || instr[9:6] == `CISA_ALU_SHR ||
				instr[9:6] == `CISA_ALU_SAR || instr[9:6] == `CISA_ALU_ROT)
				next_cycles = `CISA_CYC_SHIFT;
		end
		else if (is_f5)
		begin
			case (instr[9:8])
			`CISA_HI_ADD:
			begin
				next_wr = 1'b1;
				next_wr_val = dst_op + src_op;
			end
			`CISA_HI_CMP:
			begin
				isum = {1'b0, dst_op} + {1'b0, ~src_op} + {{WIDTH{1'b0}}, 1'b1};
				next_flags_wr = 1'b1;
				next_flags = mk_flags(isum[WIDTH-1:0], isum[WIDTH],
					(dst_op[WIDTH-1] ^ src_op[WIDTH-1]) &
					(dst_op[WIDTH-1] ^ isum[WIDTH-1]));
			end
			`CISA_HI_MOV:
			begin
				next_wr = 1'b1;
				next_wr_val = src_op;
			end
			default:
			begin
				next_branch = 1'b1;
				next_cycles = `CISA_CYC_BRANCH;
			end
			endcase
			// a write to the pc is a jump and refills the pipe
			if (next_wr && next_wr_idx == `CISA_PC_INDEX)
				next_cycles = `CISA_CYC_BRANCH;
		end
		else if (is_f6)
		begin
			next_load = 1'b1;
			next_cycles = `CISA_CYC_LOAD;
		end
	end

	// architectural state update and cycle sequencing
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			for (k = 0; k < NREGS; k = k + 1)
				regs[k] <= {WIDTH{1'b0}};
			state <= ST_IDLE;
			wait_cnt <= 3'h0;
			load_dest <= 3'h0;
			status_flags_reg <= 4'h0;
			compact_state <= 1'b1;
			branch_taken <= 1'b0;
			branch_target <= {WIDTH{1'b0}};
			mem_req <= 1'b0;
			mem_addr <= {WIDTH{1'b0}};
		end
		else
		begin
			branch_taken <= 1'b0;
			mem_req <= 1'b0;
			case (state)
			ST_IDLE:
				if (instr_valid)
				begin
					if (next_wr)
						regs[next_wr_idx] <= next_wr_val;
					if (next_flags_wr)
						status_flags_reg <= next_flags;
					if (next_branch)
					begin
						branch_taken <= 1'b1;
						branch_target <= src_op & ~{{(WIDTH-1){1'b0}}, 1'b1};
						compact_state <= src_op[0];
					end
					else if (next_wr && next_wr_idx == `CISA_PC_INDEX)
					begin
						branch_taken <= 1'b1;
						branch_target <= next_wr_val & ~{{(WIDTH-1){1'b0}}, 1'b1};
					end
					if (next_load)
					begin
						mem_req <= 1'b1;
						// word-aligned base plus offset times four
						mem_addr <= (pc_read & ~{{(WIDTH-2){1'b0}}, 2'h2}) +
							{{(WIDTH-10){1'b0}}, imm8_field, 2'h0};
						load_dest <= instr[10:8];
						state <= ST_LOAD;
					end
					else if (next_cycles != `CISA_CYC_ALU)
					begin
						wait_cnt <= next_cycles - 3'h2;
						state <= ST_WAIT;
					end
				end
			ST_WAIT:
				// pads the op to its full cycle count
				if (wait_cnt == 3'h0)
					state <= ST_IDLE;
				else
					wait_cnt <= wait_cnt - 3'h1;
			ST_LOAD:
				if (mem_rvalid)
				begin
					regs[{1'b0, load_dest}] <= mem_rdata;
					state <= ST_IDLE;
				end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// register view for debug and the rest of the core
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			reg_view <= {WIDTH{1'b0}};
		else
			reg_view <= regs[reg_view_sel];
	end
endmodule

// ===== hdl/cisa_defs.vh
// Purpose: constants for the compact instruction decode/execute block
// Assumes: 16-bit instruction halfwords, 32-bit datapath
// Notes: field positions are bit indices within the halfword
`ifndef CISA_DEFS_VH
`define CISA_DEFS_VH
// format recognition: top bits of the halfword
`define CISA_F3_TAG 3'h1
`define CISA_F4_TAG 6'h10
`define CISA_F5_TAG 6'h11
`define CISA_F6_TAG 5'h09
// immediate format opcodes
`define CISA_IMM_MOV 2'h0
`define CISA_IMM_CMP 2'h1
`define CISA_IMM_ADD 2'h2
`define CISA_IMM_SUB 2'h3
// register-pair opcodes
`define CISA_ALU_AND 4'h0
`define CISA_ALU_XOR 4'h1
`define CISA_ALU_SHL 4'h2
`define CISA_ALU_SHR 4'h3
`define CISA_ALU_SAR 4'h4
`define CISA_ALU_ADC 4'h5
`define CISA_ALU_SUBC 4'h6
`define CISA_ALU_ROT 4'h7
`define CISA_ALU_TEST 4'h8
`define CISA_ALU_NEGATE 4'h9
`define CISA_ALU_CMP 4'ha
`define CISA_ALU_CMPN 4'hb
`define CISA_ALU_OR 4'hc
`define CISA_ALU_MULT 4'hd
`define CISA_ALU_ANDN 4'he
`define CISA_ALU_NOT 4'hf
// high-register opcodes
`define CISA_HI_ADD 2'h0
`define CISA_HI_CMP 2'h1
`define CISA_HI_MOV 2'h2
`define CISA_HI_BRX 2'h3
// program counter read offset and pc register index
`define CISA_PC_AHEAD 32'h00000004
`define CISA_PC_INDEX 4'hf
// cycle counts: single-cycle data ops, multiply and register shifts take longer, branch refills pipe, load waits
`define CISA_CYC_ALU 3'h1
`define CISA_CYC_MULT 3'h4
`define CISA_CYC_SHIFT 3'h2
`define CISA_CYC_BRANCH 3'h3
`define CISA_CYC_LOAD 3'h3
// flag positions in the status flags output
`define CISA_FLAG_N 3
`define CISA_FLAG_Z 2
`define CISA_FLAG_C 1
`define CISA_FLAG_V 0
`endif

// ===== hdl/cisa_alu.v
// Purpose: combinational arithmetic and logic unit for register-pair ops
// Assumes: carry_in is the current carry flag
// Notes: shifts by amount from low byte of the shift operand
`timescale 1ns/1ps
`include "cisa_defs.vh"
module cisa_alu
#(
	parameter WIDTH = 32
)
(
	// operation select and operands
	input wire [3:0] op,
	input wire [WIDTH-1:0] dst_val,
	input wire [WIDTH-1:0] src_val,
	input wire carry_in,
	// result and flag outputs
	output reg [WIDTH-1:0] result,
	output reg carry_out,
	output reg ovf_out,
	output reg arith
);
	reg [WIDTH:0] sum;
	reg [WIDTH-1:0] rot;
	reg [7:0] amt;
	reg [2*WIDTH-1:0] prod;
	integer i;
	// one adder shared by add, subtract and compare forms
	always @*
	begin
		amt = src_val[7:0];
		sum = {(WIDTH+1){1'b0}};
		result = {WIDTH{1'b0}};
		carry_out = carry_in;
		ovf_out = 1'b0;
		arith = 1'b0;
		prod = dst_val * src_val;
		rot = dst_val;
		for (i = 0; i < WIDTH; i = i + 1)
			rot[i] = dst_val[(i + amt[4:0]) % WIDTH];
		case (op)
		`CISA_ALU_AND, `CISA_ALU_TEST: result = dst_val & src_val;
		`CISA_ALU_XOR: result = dst_val ^ src_val;
		`CISA_ALU_OR: result = dst_val | src_val;
		`CISA_ALU_ANDN: result = dst_val & ~src_val;
		`CISA_ALU_NOT: result = ~src_val;
		`CISA_ALU_SHL:
		begin
			result = (amt >= WIDTH) ? {WIDTH{1'b0}} : dst_val << amt;
			if (amt != 8'h00)
				carry_out = (amt > WIDTH) ? 1'b0 : dst_val[WIDTH - amt];
		end
		`CISA_ALU_SHR:
		begin
			result = (amt >= WIDTH) ? {WIDTH{1'b0}} : dst_val >> amt;
			if (amt != 8'h00)
				carry_out = (amt > WIDTH) ? 1'b0 : dst_val[amt - 1];
		end
		`CISA_ALU_SAR:
		begin
			// kept apart: a conditional with an unsigned arm would drop the sign fill
			if (amt >= WIDTH)
				result = {WIDTH{dst_val[WIDTH-1]}};
			else
				result = $signed(dst_val) >>> amt;
			if (amt != 8'h00)
				carry_out = (amt >= WIDTH) ? dst_val[WIDTH-1] : dst_val[amt - 1];
		end
		`CISA_ALU_ROT:
		begin
			result = rot;
			if (amt != 8'h00)
				carry_out = rot[WIDTH-1];
		end
		`CISA_ALU_ADC, `CISA_ALU_CMPN:
		begin
			sum = {1'b0, dst_val} + {1'b0, src_val} +
				{{WIDTH{1'b0}}, (op == `CISA_ALU_ADC) ? carry_in : 1'b0};
			arith = 1'b1;
		end
		`CISA_ALU_SUBC, `CISA_ALU_CMP:
		begin
			sum = {1'b0, dst_val} + {1'b0, ~src_val} +
				{{WIDTH{1'b0}}, (op == `CISA_ALU_SUBC) ? carry_in : 1'b1};
			arith = 1'b1;
		end
		`CISA_ALU_NEGATE:
		begin
			sum = {1'b0, ~src_val} + {{WIDTH{1'b0}}, 1'b1};
			arith = 1'b1;
		end
		`CISA_ALU_MULT: result = prod[WIDTH-1:0];
		default: result = {WIDTH{1'b0}};
		endcase
		if (arith)
		begin
			result = sum[WIDTH-1:0];
			carry_out = sum[WIDTH];
			if (op == `CISA_ALU_NEGATE)
				ovf_out = src_val[WIDTH-1] & result[WIDTH-1];
			else if (op == `CISA_ALU_SUBC || op == `CISA_ALU_CMP)
				ovf_out = (dst_val[WIDTH-1] ^ src_val[WIDTH-1]) &
					(dst_val[WIDTH-1] ^ result[WIDTH-1]);
			else
				ovf_out = ~(dst_val[WIDTH-1] ^ src_val[WIDTH-1]) &
					(dst_val[WIDTH-1] ^ result[WIDTH-1]);
		end
	end
endmodule

// ===== test/cisa_core_chk.sv
// Purpose: port-level timing and flag checks for cisa_core
// Assumes: flags packed {n,z,c,v}, one instruction taken per handshake
// Notes: bound to every cisa_core instance
`timescale 1ns/1ps
module cisa_core_chk
#(
	parameter WIDTH = 32
)
(
	// clock and reset
	input wire clock,
	input wire rst,
	// fetch side
	input wire instr_valid,
	input wire [15:0] instr,
	input wire [WIDTH-1:0] instr_addr,
	input wire instr_ready,
	// load path
	input wire mem_req,
	input wire [WIDTH-1:0] mem_addr,
	// state outputs
	input wire [3:0] status_flags_reg,
	input wire compact_state,
	input wire branch_taken,
	input wire [WIDTH-1:0] branch_target
);
	// decode of the taken halfword
	wire take = instr_valid && instr_ready;
	wire alu = take && instr[15:10] == 6'h10;
	wire mult = alu && instr[9:6] == 4'hd;
	wire shf = alu && (instr[9:6] inside {4'h2, 4'h3, 4'h4, 4'h7});
	wire brx = take && instr[15:8] == 8'h47;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	property p_mult_cyc;
		mult |=> !instr_ready [*3] ##1 instr_ready;
	endproperty
	a_mult_cyc: assert property (p_mult_cyc) else $error("multiply cycles wrong");
	property p_shf_cyc;
		shf |=> !instr_ready ##1 instr_ready;
	endproperty
	a_shf_cyc: assert property (p_shf_cyc) else $error("shift cycles wrong");
	property p_alu_cyc;
		(alu && !mult && !shf) || (take && instr[15:13] == 3'h1) |=> instr_ready;
	endproperty
	a_alu_cyc: assert property (p_alu_cyc) else $error("single cycle op stalled");
	property p_mov_nz;
		take && instr[15:11] == 5'h04 |=> status_flags_reg[3:2] == {1'b0, $past(instr[7:0]) == 8'h00};
	endproperty
	a_mov_nz: assert property (p_mov_nz) else $error("move flags wrong");
	property p_hi_keep;
		take && (instr[15:8] inside {8'h44, 8'h46}) |=> $stable(status_flags_reg);
	endproperty
	a_hi_keep: assert property (p_hi_keep) else $error("high add or move changed flags");
	property p_ld_addr;
		take && instr[15:11] == 5'h09 |=> mem_req &&
			mem_addr == ((($past(instr_addr) + 32'h4) & ~32'h3) + {$past(instr[7:0]), 2'h0});
	endproperty
	a_ld_addr: assert property (p_ld_addr) else $error("load address wrong");
	property p_ld_hold;
		mem_req |-> !instr_ready;
	endproperty
	a_ld_hold: assert property (p_ld_hold) else $error("ready during load");
	property p_brx_pc;
		take && instr == 16'h4778 |=> !compact_state &&
			branch_target == (($past(instr_addr) + 32'h4) & ~32'h1);
	endproperty
	a_brx_pc: assert property (p_brx_pc) else $error("branch on pc wrong");
	property p_brx_cyc;
		brx |=> branch_taken && !instr_ready ##1 !branch_taken && !instr_ready ##1 instr_ready;
	endproperty
	a_brx_cyc: assert property (p_brx_cyc) else $error("branch pulse or cycles wrong");
	c_mult: cover property (mult);
	c_load: cover property (mem_req);
	c_brx: cover property (brx);
endmodule

bind cisa_core cisa_core_chk #(.WIDTH(WIDTH)) chk_u
(
	.clock(clock),
	.rst(rst),
	.instr_valid(instr_valid),
	.instr(instr),
	.instr_addr(instr_addr),
	.instr_ready(instr_ready),
	.mem_req(mem_req),
	.mem_addr(mem_addr),
	.status_flags_reg(status_flags_reg),
	.compact_state(compact_state),
	.branch_taken(branch_taken),
	.branch_target(branch_target)
);

// ===== test/compact_isa_alu_hireg_branch_decode_tb.sv
// Purpose: self-checking bench for cisa_core
// Assumes: one idle cycle between instructions, inputs driven at falling edges
// Notes: registers are read back through reg_view, flags through status_flags_reg, while idle
`timescale 1ns/1ps
module compact_isa_alu_hireg_branch_decode_tb;
	reg clock = 0;
	reg rst = 1;
	reg instr_valid = 0;
	reg [15:0] instr = 16'h0000;
	reg [31:0] instr_addr = 32'h00000000;
	reg mem_rvalid = 0;
	reg [31:0] mem_rdata = 32'h00000000;
	reg [3:0] reg_view_sel = 4'h0;
	wire instr_ready, mem_req, compact_state, branch_taken;
	wire [31:0] mem_addr, branch_target, reg_view;
	wire [3:0] status_flags_reg;
	integer mismatches = 0;
	integer total_checks = 0;
	reg vgo = 0;
	reg [36:0] val_q[$];
	reg [31:0] adr_q[$];
	reg [31:0] tgt_q[$];
	reg [31:0] a, b, r, t;
	reg [3:0] nz;
	integer i, j, k;

	cisa_core dut_u
	(
		.clock(clock),
		.rst(rst),
		.instr_valid(instr_valid),
		.instr(instr),
		.instr_addr(instr_addr),
		.instr_ready(instr_ready),
		.mem_req(mem_req),
		.mem_addr(mem_addr),
		.mem_rvalid(mem_rvalid),
		.mem_rdata(mem_rdata),
		.status_flags_reg(status_flags_reg),
		.compact_state(compact_state),
		.branch_taken(branch_taken),
		.branch_target(branch_target),
		.reg_view(reg_view),
		.reg_view_sel(reg_view_sel)
	);

	// 200 MHz core clock
	initial
		forever #2.5 clock = ~clock;

	task chk(input string n, input [36:0] e, input [36:0] g);
		total_checks = total_checks + 1;
		if (g !== e)
		begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask

	// one compare task per kind of result
	task cmp_view(input [36:0] e, input [36:0] g);
		chk("reg view", e, g);
	endtask

	task cmp_addr(input [31:0] e, input [31:0] g);
		chk("load addr", {5'h0, e}, {5'h0, g});
	endtask

	task cmp_tgt(input [31:0] e, input [31:0] g);
		chk("branch target", {5'h0, e}, {5'h0, g});
	endtask

	task results;
		if (mismatches == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task tmo;
		mismatches = mismatches + 1;
		results;
	endtask

	// waits for ready under a bound, then offers one halfword for one cycle
	task run(input [15:0] w);
		@(negedge clock);
		for (k = 0; k < 60 && !instr_ready; k = k + 1)
			@(negedge clock);
		if (k == 60)
			tmo;
		instr = w;
		instr_valid = 1;
		@(negedge clock);
		instr_valid = 0;
	endtask

	// reg_view lags the select by a cycle, so the monitor looks one cycle on
	task view(input [3:0] s, input [36:0] e);
		reg_view_sel = s;
		val_q.push_back(e);
		@(negedge clock);
		vgo <= 1;
		@(negedge clock);
		vgo <= 0;
	endtask

	function [3:0] fnz(input [31:0] v);
		fnz = {v[31], v == 32'h0, 2'h0};
	endfunction

	// reference results with the carry flag known to be set
	function [31:0] alu(input [3:0] o, input [31:0] d, input [31:0] s);
		case (o)
			4'h0, 4'h8: alu = d & s;
			4'h1: alu = d ^ s;
			4'h2: alu = d << s[7:0];
			4'h3: alu = d >> s[7:0];
			4'h4: alu = $signed(d) >>> s[7:0];
			4'h5: alu = d + s + 32'h1;
			4'h6, 4'ha: alu = d - s;
			4'h7: alu = (d >> s[4:0]) | (d << (6'h20 - s[4:0]));
			4'h9: alu = 32'h0 - s;
			4'hb: alu = d + s;
			4'hc: alu = d | s;
			4'hd: alu = d * s;
			4'he: alu = d & ~s;
			default: alu = ~s;
		endcase
	endfunction

	// expected carry and overflow; carry set and overflow clear beforehand
	function [1:0] fcv(input [3:0] o, input [31:0] d, input [31:0] s);
		reg [32:0] w;
		reg [31:0] q;
		begin
			fcv = 2'h2;
			q = alu(o, d, s);
			case (o)
				4'h2: w = {1'b0, d} << s[7:0];
				4'h3: w = {d, 1'b0} >> s[7:0];
				4'h4: w = $signed({d, 1'b0}) >>> s[7:0];
				4'h5: w = {1'b0, d} + {1'b0, s} + 33'h1;
				4'h6, 4'ha: w = {1'b0, d} + {1'b0, ~s} + 33'h1;
				4'h9: w = {1'b0, ~s} + 33'h1;
				4'hb: w = {1'b0, d} + {1'b0, s};
				default: w = 33'h0;
			endcase
			// a shift by zero leaves carry alone
			if (o == 4'h2 && s[7:0] != 8'h00)
				fcv[1] = w[32];
			if ((o == 4'h3 || o == 4'h4) && s[7:0] != 8'h00)
				fcv[1] = w[0];
			if (o == 4'h7 && s[7:0] != 8'h00)
				fcv[1] = q[31];
			if (o inside {4'h5, 4'h6, 4'h9, 4'ha, 4'hb})
			begin
				fcv[1] = w[32];
				if (o == 4'h9)
					fcv[0] = s[31] & w[31];
				else if (o == 4'h5 || o == 4'hb)
					fcv[0] = (d[31] == s[31]) && (w[31] != d[31]);
				else
					fcv[0] = (d[31] != s[31]) && (w[31] != d[31]);
			end
		end
	endfunction

	// oldest note is compared whenever the core shows a result
	always @(negedge clock)
	begin
		if (vgo)
			cmp_view(val_q.pop_front(), {compact_state, status_flags_reg, reg_view});
		if (mem_req)
			cmp_addr(adr_q.pop_front(), mem_addr);
		if (branch_taken)
			cmp_tgt(tgt_q.pop_front(), branch_target);
	end

	initial
	begin
		k = $urandom(53);
		repeat (3) @(negedge clock);
		rst = 0;
		// immediate forms on r3 after a move of a known start value
		for (i = 0; i < 4; i = i + 1)
		begin
			a = $urandom % 256;
			b = $urandom % 256;
			run({5'h04, 3'h3, a[7:0]});
			run({3'h1, i[1:0], 3'h3, b[7:0]});
			r = (i == 1 || i == 3) ? a - b : (i == 2) ? a + b : b;
			view(4'h3, {1'b1, fnz(r) | {2'h0, i[0] && a >= b, 1'b0}, (i == 1) ? a : r});
		end
		// every register-pair op, odd passes on an inverted (negative) operand
		for (i = 0; i < 32; i = i + 1)
		begin
			a = $urandom % 256;
			b = $urandom % 48;
			run({5'h04, 3'h1, a[7:0]});
			run({5'h04, 3'h2, b[7:0]});
			if (i[0])
			begin
				run(16'h43c9);
				a = ~a;
			end
			run(16'h2900);
			run({6'h10, i[4:1], 6'h11});
			r = alu(i[4:1], a, b);
			view(4'h1, {1'b1, fnz(r) | fcv(i[4:1], a, b),
				(i[4:1] inside {4'h8, 4'ha, 4'hb}) ? a : r});
		end
		// high registers: move, add keeping zero and carry, compare borrowing negative
		a = $urandom % 255 + 1;
		r = a + a;
		run({5'h04, 3'h1, a[7:0]});
		run(16'h4689);
		run({5'h05, 3'h1, a[7:0]});
		run(16'h44c9);
		view(4'h9, {1'b1, 4'h6, r});
		run(16'h4549);
		view(4'h9, {1'b1, 4'h8, r});
		// branch on the pc needs a word-aligned address
		instr_addr = $urandom & 32'hfffffffc;
		tgt_q.push_back(instr_addr + 32'h4);
		run(16'h4778);
		view(4'h9, {1'b0, 4'h8, r});
		for (j = 0; j < 2; j = j + 1)
		begin
			t = ($urandom % 256) & 32'hfe | j;
			nz = fnz(t);
			run({5'h04, 3'h2, t[7:0]});
			tgt_q.push_back(t & 32'hfffffffe);
			run(16'h4710);
			view(4'h2, {j[0], nz, t});
		end
		// pc-relative loads, largest offset first, memory answers late
		for (j = 0; j < 3; j = j + 1)
		begin
			a = (j == 0) ? 255 : $urandom % 256;
			instr_addr = $urandom & 32'hfffffffe;
			b = $urandom;
			adr_q.push_back(((instr_addr + 32'h4) & 32'hfffffffc) + {a[7:0], 2'h0});
			run({5'h09, 3'h4, a[7:0]});
			for (k = 0; k < 20 && !mem_req; k = k + 1)
				@(negedge clock);
			if (k == 20)
				tmo;
			repeat ($urandom % 3) @(negedge clock);
			mem_rdata = b;
			mem_rvalid = 1;
			@(negedge clock);
			mem_rvalid = 0;
			mem_rdata = ~b;
			view(4'h4, {1'b1, nz, b});
		end
		// every noted result must have shown up
		@(negedge clock);
		chk("notes left", 37'h0, {5'h0, val_q.size() + adr_q.size() + tgt_q.size()});
		results;
	end
endmodule
